// File: hdl/jef_pkg.sv
// shared constants and types for the test and emulation port
`default_nettype none
package jef_pkg;
  // tap controller states, one-hot
  typedef enum logic [15:0] {
    JEF_TLR  = 16'h0001,
    JEF_RTI  = 16'h0002,
    JEF_SDRS = 16'h0004,
    JEF_CDR  = 16'h0008,
    JEF_SDR  = 16'h0010,
    JEF_E1DR = 16'h0020,
    JEF_PDR  = 16'h0040,
    JEF_E2DR = 16'h0080,
    JEF_UDR  = 16'h0100,
    JEF_SIRS = 16'h0200,
    JEF_CIR  = 16'h0400,
    JEF_SIR  = 16'h0800,
    JEF_E1IR = 16'h1000,
    JEF_PIR  = 16'h2000,
    JEF_E2IR = 16'h4000,
    JEF_UIR  = 16'h8000
  } jef_tap_t;

  localparam int JEF_IR_W = 4;
  localparam logic [JEF_IR_W-1:0] JEF_IR_CAPTURE = 4'h1;
  localparam logic [JEF_IR_W-1:0] JEF_IR_IDCODE = 4'h1;
  localparam logic [JEF_IR_W-1:0] JEF_IR_EMUCTL = 4'h2;
  localparam logic [JEF_IR_W-1:0] JEF_IR_BYPASS = 4'hf;

  localparam int JEF_DR_W = 32;
  // emulation control register: pin direction and drive value
  localparam int JEF_CTL_W = 4;
  localparam int JEF_CTL_A_OE = 0;
  localparam int JEF_CTL_A_VAL = 1;
  localparam int JEF_CTL_B_OE = 2;
  localparam int JEF_CTL_B_VAL = 3;
  localparam logic [JEF_CTL_W-1:0] JEF_CTL_RESET = 4'h0;
  localparam int JEF_EMUCTL_LEN = JEF_CTL_W + 2;
  localparam int JEF_IDCODE_LEN = 32;
  localparam int JEF_BYPASS_LEN = 1;

  // synchroniser bit positions
  localparam int JEF_PIN_W = 6;
  localparam int JEF_P_TCK = 0;
  localparam int JEF_P_TMS = 1;
  localparam int JEF_P_TDI = 2;
  localparam int JEF_P_TRST = 3;
  localparam int JEF_P_EMUA = 4;
  localparam int JEF_P_EMUB = 5;
endpackage
`default_nettype wire

// File: hdl/jef_test_port.sv
// boundary-scan tap, emulator event pins and output-float control
// Overview of operation
// - tms and tdi are taken into tap, ir or data register on tck rise
// - tdo changes only on tck fall, shifting the selected register out
// - tdo is high impedance except while a register is being shifted out
// - tdo is high impedance whenever the output-float request is active
// - with trst high the scan system controls the port
// - with trst low tck, tms and tdi are ignored
// - with trst high pin a is an emulator event line, direction set by scan
// - with trst high pin b is an emulator event line, direction set by scan
// - with trst low pin b becomes the active-low float request input
// - trst low, pin a high, pin b low: every output driver floats
// - host ready and host interrupt outputs float during output float
`default_nettype none
module jef_test_port
  import jef_pkg::*;
#(
  // arbitrary identification value; bit 0 must be one
  parameter logic [JEF_DR_W-1:0] ID_VALUE = 32'h0000_0001
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic trst_in,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic emulator_event_pin_a_in,
  output logic emulator_event_pin_a_out,
  output logic emulator_event_pin_a_oe,
  input wire logic emulator_event_pin_b_or_float_in,
  output logic emulator_event_pin_b_or_float_out,
  output logic emulator_event_pin_b_or_float_oe,
  input wire logic host_ready_core,
  input wire logic host_int_core,
  output logic host_port_ready_out,
  output logic host_port_ready_oe,
  output logic host_port_interrupt_out,
  output logic host_port_interrupt_oe,
  output logic all_outputs_float,
  output logic scan_mode
);

  if (ID_VALUE[0] != 1'b1) begin : g_bad_id
    $error("ID_VALUE bit 0 must be one");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [JEF_PIN_W-1:0] sync1_q;
  logic [JEF_PIN_W-1:0] sync2_q;
  logic tck_prev_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      tck_prev_q <= 1'b0;
    end else begin
      sync1_q <= {emulator_event_pin_b_or_float_in, emulator_event_pin_a_in, trst_in,
                  tdi_in, tms_in, tck_in};
      sync2_q <= sync1_q;
      tck_prev_q <= sync2_q[JEF_P_TCK];
    end
  end

  logic trst_s;
  logic tms_s;
  logic tdi_s;
  logic emu_a_s;
  logic emu_b_s;
  logic tck_rise;
  logic tck_fall;
  logic float_req;

  assign trst_s = sync2_q[JEF_P_TRST];
  assign tms_s = sync2_q[JEF_P_TMS];
  assign tdi_s = sync2_q[JEF_P_TDI];
  assign emu_a_s = sync2_q[JEF_P_EMUA];
  assign emu_b_s = sync2_q[JEF_P_EMUB];
  // edges only count in scan mode; tck is ignored otherwise
  // trst must stand high a cycle first: sync flops leave reset low and would fake a tck rise
  assign tck_rise = trst_s & scan_mode & sync2_q[JEF_P_TCK] &
                    ~tck_prev_q;
  assign tck_fall = trst_s & scan_mode & ~sync2_q[JEF_P_TCK] & tck_prev_q;
  assign float_req = ~trst_s & emu_a_s & ~emu_b_s;

  //////////////////////////////////////////////////////////////////////////////
  // tap controller
  jef_tap_t state_q;
  jef_tap_t state_d;

  always_comb begin
    state_d = state_q;
    if (!trst_s) begin
      state_d = JEF_TLR;
    end else if (tck_rise) begin
      case (state_q)
        JEF_TLR: state_d = tms_s ? JEF_TLR : JEF_RTI;
        JEF_RTI: state_d = tms_s ? JEF_SDRS : JEF_RTI;
        JEF_SDRS: state_d = tms_s ? JEF_SIRS : JEF_CDR;
        JEF_CDR: state_d = tms_s ? JEF_E1DR : JEF_SDR;
        JEF_SDR: state_d = tms_s ? JEF_E1DR : JEF_SDR;
        JEF_E1DR: state_d = tms_s ? JEF_UDR : JEF_PDR;
        JEF_PDR: state_d = tms_s ? JEF_E2DR : JEF_PDR;
        JEF_E2DR: state_d = tms_s ? JEF_UDR : JEF_SDR;
        JEF_UDR: state_d = tms_s ? JEF_SDRS : JEF_RTI;
        JEF_SIRS: state_d = tms_s ? JEF_TLR : JEF_CIR;
        JEF_CIR: state_d = tms_s ? JEF_E1IR : JEF_SIR;
        JEF_SIR: state_d = tms_s ? JEF_E1IR : JEF_SIR;
        JEF_E1IR: state_d = tms_s ? JEF_UIR : JEF_PIR;
        JEF_PIR: state_d = tms_s ? JEF_E2IR : JEF_PIR;
        JEF_E2IR: state_d = tms_s ? JEF_UIR : JEF_SIR;
        JEF_UIR: state_d = tms_s ? JEF_SDRS : JEF_RTI;
        default: state_d = JEF_TLR;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // instruction, data and emulation control registers
  logic [JEF_IR_W-1:0] ir_sh_q;
  logic [JEF_IR_W-1:0] ir_sh_d;
  logic [JEF_IR_W-1:0] ir_q;
  logic [JEF_IR_W-1:0] ir_d;
  logic [JEF_DR_W-1:0] dr_sh_q;
  logic [JEF_DR_W-1:0] dr_sh_d;
  logic [JEF_CTL_W-1:0] ctl_q;
  logic [JEF_CTL_W-1:0] ctl_d;

  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    dr_sh_d = dr_sh_q;
    ctl_d = ctl_q;
    if (state_q == JEF_TLR) begin
      ir_d = JEF_IR_IDCODE;
      ctl_d = JEF_CTL_RESET;
    end
    if (tck_rise) begin
      case (state_q)
        JEF_CIR: ir_sh_d = JEF_IR_CAPTURE;
        JEF_SIR: ir_sh_d = {tdi_s, ir_sh_q[JEF_IR_W-1:1]};
        JEF_UIR: ir_d = ir_sh_q;
        JEF_CDR: begin
          if (ir_q == JEF_IR_IDCODE) begin
            dr_sh_d = ID_VALUE;
          end else if (ir_q == JEF_IR_EMUCTL) begin
            dr_sh_d = '0;
            // pin levels are captured so the emulator can read incoming events
            dr_sh_d[JEF_EMUCTL_LEN-1:0] = {emu_b_s, emu_a_s, ctl_q};
          end else begin
            dr_sh_d = '0;
          end
        end
        JEF_SDR: begin
          // shorter registers insert tdi at their own top bit
          dr_sh_d = {1'b0, dr_sh_q[JEF_DR_W-1:1]};
          if (ir_q == JEF_IR_IDCODE) begin
            dr_sh_d[JEF_IDCODE_LEN-1] = tdi_s;
          end else if (ir_q == JEF_IR_EMUCTL) begin
            dr_sh_d[JEF_EMUCTL_LEN-1] = tdi_s;
          end else begin
            dr_sh_d[JEF_BYPASS_LEN-1] = tdi_s;
          end
        end
        JEF_UDR: begin
          if (ir_q == JEF_IR_EMUCTL) begin
            ctl_d = dr_sh_q[JEF_CTL_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers
  logic shifting;
  logic tdo_d;
  logic tdo_oe_d;
  logic emu_a_out_d;
  logic emu_a_oe_d;
  logic emu_b_out_d;
  logic emu_b_oe_d;

  assign shifting = (state_q == JEF_SIR) || (state_q == JEF_SDR);

  always_comb begin
    tdo_d = tdo_out;
    tdo_oe_d = tdo_oe;
    if (!trst_s || float_req) begin
      tdo_oe_d = 1'b0;
    end else if (tck_fall) begin
      tdo_d = (state_q == JEF_SIR) ? ir_sh_q[0] : dr_sh_q[0];
      tdo_oe_d = shifting;
    end
    emu_a_out_d = trst_s & ctl_q[JEF_CTL_A_VAL];
    emu_a_oe_d = trst_s & ctl_q[JEF_CTL_A_OE];
    emu_b_out_d = trst_s & ctl_q[JEF_CTL_B_VAL];
    // pin b is always input while trst is low so the float request can be seen
    emu_b_oe_d = trst_s & ctl_q[JEF_CTL_B_OE];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= JEF_TLR;
      ir_sh_q <= JEF_IR_CAPTURE;
      ir_q <= JEF_IR_IDCODE;
      dr_sh_q <= '0;
      ctl_q <= JEF_CTL_RESET;
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
      emulator_event_pin_a_out <= 1'b0;
      emulator_event_pin_a_oe <= 1'b0;
      emulator_event_pin_b_or_float_out <= 1'b0;
      emulator_event_pin_b_or_float_oe <= 1'b0;
      host_port_ready_out <= 1'b0;
      host_port_ready_oe <= 1'b0;
      host_port_interrupt_out <= 1'b0;
      host_port_interrupt_oe <= 1'b0;
      all_outputs_float <= 1'b0;
      scan_mode <= 1'b0;
    end else begin
      state_q <= state_d;
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
      dr_sh_q <= dr_sh_d;
      ctl_q <= ctl_d;
      tdo_out <= tdo_d;
      tdo_oe <= tdo_oe_d;
      emulator_event_pin_a_out <= emu_a_out_d;
      emulator_event_pin_a_oe <= emu_a_oe_d;
      emulator_event_pin_b_or_float_out <= emu_b_out_d;
      emulator_event_pin_b_or_float_oe <= emu_b_oe_d;
      host_port_ready_out <= host_ready_core;
      host_port_ready_oe <= ~float_req;
      host_port_interrupt_out <= host_int_core;
      host_port_interrupt_oe <= ~float_req;
      all_outputs_float <= float_req;
      scan_mode <= trst_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_tdo_fall_only: assert property (
    $past(rst_n) && $changed(tdo_out) |-> $past(tck_fall))
    else $error("tdo changed without a tck fall");
  a_tdo_on_shift: assert property (
    $rose(tdo_oe) |-> $past(tck_fall) && $past(shifting))
    else $error("tdo enabled outside a shift");
  a_float_tdo_off: assert property (
    all_outputs_float |-> !tdo_oe)
    else $error("tdo driven during output float");
  a_tap_leaves_reset: assert property (
    state_q == JEF_TLR && tck_rise && !tms_s |=> state_q == JEF_RTI)
    else $error("tap did not move to idle");
  a_trst_holds_tap: assert property (
    !trst_s |=> state_q == JEF_TLR && !tdo_oe)
    else $error("tap not held in reset");
  a_tap_edge_only: assert property (
    trst_s && !tck_rise |=> state_q == $past(state_q))
    else $error("tap moved without tck rise");
  a_pin_a_dir: assert property (
    $past(rst_n) && $past(trst_s) |-> emulator_event_pin_a_oe == $past(ctl_q[JEF_CTL_A_OE]))
    else $error("pin a direction not from scan control");
  a_pin_b_dir: assert property (
    $past(rst_n) && $past(trst_s) |->
      emulator_event_pin_b_or_float_oe == $past(ctl_q[JEF_CTL_B_OE]))
    else $error("pin b direction not from scan control");
  a_ctl_update: assert property (
    tck_rise && state_q == JEF_UDR && ir_q == JEF_IR_EMUCTL |=> ctl_q == $past(dr_sh_q[JEF_CTL_W-1:0]))
    else $error("control register not updated from scan");
  a_ir_update: assert property (
    tck_rise && state_q == JEF_UIR |=> ir_q == $past(ir_sh_q))
    else $error("instruction not updated from scan");
  a_pin_b_input: assert property (
    !trst_s |=> !emulator_event_pin_b_or_float_oe)
    else $error("pin b driven while trst low");
  a_float_decode: assert property (
    !trst_s && emu_a_s && !emu_b_s |=> all_outputs_float ##1 !emulator_event_pin_a_oe)
    else $error("float condition not taken");
  a_host_float: assert property (
    all_outputs_float |-> !host_port_ready_oe && !host_port_interrupt_oe)
    else $error("host outputs driven during float");

  c_shift_dr: cover property (state_q == JEF_SDR && tck_fall ##[1:20] tdo_oe);
  c_ctl_update: cover property (state_q == JEF_UDR && tck_rise && ir_q == JEF_IR_EMUCTL);
  c_float: cover property ($rose(all_outputs_float));
  c_bypass_shift: cover property (state_q == JEF_SDR && tck_rise && ir_q == JEF_IR_BYPASS);

endmodule
`default_nettype wire

// File: sim/jef_scan_ctl.sv
// model of the external scan and emulation controller
`default_nettype none
module jef_scan_ctl (
  input wire logic sys_clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic a_en,
  output logic a_val,
  output logic b_en,
  output logic b_val
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
    trst = 1'b0;
    a_en = 1'b0;
    a_val = 1'b1;
    b_en = 1'b0;
    b_val = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one 64 ns tck period; tck stands high between calls, tdo taken before the rise
  task automatic tap_cycle(input logic m, input logic d, output logic o, output logic oe);
    @(posedge sys_clk);
    #1;
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (8) @(posedge sys_clk);
    #1;
    o = tdo_oe ? tdo : !tdo; // released tdo has no pull: show the inverse
    oe = tdo_oe;
    tck = 1'b1;
    repeat (7) @(posedge sys_clk);
  endtask
  // float asked only from the test scenarios, never to share a bus
  task automatic float_req(input logic req, input logic a_low);
    a_en = 1'b1;
    a_val = !a_low; // pin a held high to allow float, driven low instead when a_low is set
    b_en = 1'b1;
    b_val = !req;
  endtask
endmodule
`default_nettype wire

// File: sim/jef_test_port_tb.sv
// self-checking bench for the test and emulation port
`default_nettype none
module jef_test_port_tb;
  import jef_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID_TB = 32'h1357_9bdf; // arbitrary value, bit 0 set
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hr_core = 1'b0;
  logic hi_core = 1'b0;
  logic req, alow, exp_f, o, oe;
  logic [31:0] got;
  logic [3:0] cv;
  logic [3:0] pcv = 4'h0;
  logic [1:0] expc;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  wire logic tck, tms, tdi, trst, tdo, tdo_oe, a_out, a_oe, b_out, b_oe, a_en, a_val, b_en, b_val;
  wire logic hr_out, hr_oe, hi_out, hi_oe, flt, scan, pa, pb;
  function automatic logic lvl(input logic e, input logic q, input logic pe, input logic pv);
    return e ? q : (pe ? pv : 1'b1); // both pins pulled up
  endfunction
  function automatic logic float_exp(input logic t, input logic a, input logic b);
    return !t && a && !b;
  endfunction
  assign pa = lvl(a_oe, a_out, a_en, a_val);
  assign pb = lvl(b_oe, b_out, b_en, b_val);
  jef_scan_ctl u_ctl (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .trst(trst),
    .tdo(tdo), .tdo_oe(tdo_oe), .a_en(a_en), .a_val(a_val), .b_en(b_en), .b_val(b_val));
  jef_test_port #(.ID_VALUE(ID_TB)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .tck_in(tck),
    .tms_in(tms), .tdi_in(tdi), .trst_in(trst), .tdo_out(tdo), .tdo_oe(tdo_oe),
    .emulator_event_pin_a_in(pa), .emulator_event_pin_a_out(a_out),
    .emulator_event_pin_a_oe(a_oe), .emulator_event_pin_b_or_float_in(pb),
    .emulator_event_pin_b_or_float_out(b_out), .emulator_event_pin_b_or_float_oe(b_oe),
    .host_ready_core(hr_core), .host_int_core(hi_core), .host_port_ready_out(hr_out),
    .host_port_ready_oe(hr_oe), .host_port_interrupt_out(hi_out),
    .host_port_interrupt_oe(hi_oe), .all_outputs_float(flt), .scan_mode(scan));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got_v);
    checked++;
    if (got_v !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got_v);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic walk(input logic [15:0] m, input int n);
    logic wo, woe;
    for (int i = 0; i < n; i++) u_ctl.tap_cycle(m[i], 1'b0, wo, woe);
  endtask
  // shift n bits lsb first, then update and return to idle
  task automatic scan_reg(input int n, input logic [31:0] v, output logic [31:0] g);
    logic so, soe;
    g = '0;
    for (int i = 0; i < n; i++) begin
      u_ctl.tap_cycle(i == n - 1, v[i], so, soe);
      g[i] = so;
      chk("tdo_oe in shift", 32'(1'b1), 32'(soe));
    end
    u_ctl.tap_cycle(1'b1, 1'b0, so, soe);
    chk("tdo_oe after shift", 32'(1'b0), 32'(soe));
    u_ctl.tap_cycle(1'b0, 1'b0, so, soe);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(83));
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      #1;
      req = (i == 0) ? 1'b1 : 1'($urandom);
      alow = (i == 1) || (i > 4 && 1'($urandom));
      u_ctl.float_req(req, alow);
      hr_core = 1'($urandom);
      hi_core = 1'($urandom);
      repeat (5) @(posedge sys_clk);
      exp_f = float_exp(1'b0, pa, pb);
      chk("all_outputs_float", 32'(exp_f), 32'(flt));
      chk("host ready oe", 32'(!exp_f), 32'(hr_oe));
      chk("host int oe", 32'(!exp_f), 32'(hi_oe));
      chk("tdo_oe in float", 32'(1'b0), 32'(tdo_oe));
      chk("pin b oe", 32'(1'b0), 32'(b_oe));
      if (!exp_f) chk("host ready", 32'(hr_core), 32'(hr_out));
      if (!exp_f) chk("host int", 32'(hi_core), 32'(hi_out));
    end
    #1 u_ctl.float_req(1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      u_ctl.tap_cycle(1'($urandom), 1'($urandom), o, oe);
      chk("tdo_oe trst low", 32'(1'b0), 32'(oe));
      chk("scan_mode low", 32'(1'b0), 32'(scan));
    end
    $display("test float done");
    @(posedge sys_clk);
    #1 u_ctl.trst = 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("scan_mode high", 32'(1'b1), 32'(scan));
    walk(16'h00df, 10);
    scan_reg(4, 32'(JEF_IR_EMUCTL), got);
    chk("ir capture", 32'(JEF_IR_CAPTURE), 32'(got[3:0]));
    for (int i = 0; i < 5; i++) begin
      #1;
      cv = (i == 0) ? 4'hf : 4'($urandom);
      u_ctl.a_en = !a_oe;
      u_ctl.a_val = 1'($urandom);
      u_ctl.b_en = !b_oe;
      u_ctl.b_val = 1'($urandom);
      walk(16'h0001, 3);
      expc = {pb, pa};
      scan_reg(6, {26'h0, 2'b00, cv}, got);
      chk("captured pin levels", 32'(expc), 32'(got[5:4]));
      chk("ctl readback", 32'(pcv), 32'(got[3:0]));
      pcv = cv;
      repeat (5) @(posedge sys_clk);
      chk("pin a drive", 32'({cv[0], cv[0] & cv[1]}), 32'({a_oe, a_oe & a_out}));
      chk("pin b drive", 32'({cv[2], cv[2] & cv[3]}), 32'({b_oe, b_oe & b_out}));
    end
    $display("test scan done");
    @(posedge sys_clk);
    #1 u_ctl.trst = 1'b0;
    u_ctl.a_en = 1'b0;
    u_ctl.b_en = 1'b0;
    repeat (5) @(posedge sys_clk);
    chk("pins off trst low", 32'(2'b00), 32'({a_oe, b_oe}));
    chk("tdo_oe trst low", 32'(1'b0), 32'(tdo_oe));
    #1 u_ctl.trst = 1'b1;
    repeat (5) @(posedge sys_clk);
    walk(16'h0002, 4);
    scan_reg(32, $urandom, got);
    chk("id register", ID_TB, got);
    chk("ctl reset", 32'(2'b00), 32'({a_oe, b_oe}));
    $display("test tap reset done");
    walk(16'h0003, 4);
    scan_reg(4, 32'(JEF_IR_BYPASS), got);
    chk("ir capture", 32'(JEF_IR_CAPTURE), 32'(got[3:0]));
    walk(16'h0001, 3);
    cv = 4'($urandom);
    scan_reg(8, {24'h0, cv, 4'h5}, got);
    chk("bypass delay", {24'h0, cv[2:0], 4'h5, 1'b0}, got);
    $display("test bypass done");
    end_sim();
  end
endmodule
`default_nettype wire
